// File: logic/tsf_frame_sync.sv
// Behaviour
// - wake window count is 7 bits, 0..127
// - count zero, random/equal: wake at sync
// - count zero in pattern mode: no wake
// - wake pattern compared only when register full
// - start on sync (slave) or wake (polling)
// - search until match or sync lost
// - two 16-chip correlators on Manchester chips
// - each correlator uses only its length
// - pattern A and B from byte pairs
// - two config sets, selected one governs
// - mode selects one of four arrangements
// - single mode concatenates into 32 chips
// - parallel: a match of either correlator gives sync
// - gap mode: A, then gap, then B
// - extended mode emits A/B indicator bit
// - patterns may contain code violations
// - three equal chips is a violation
// - criterion codes pattern/random/equal/rate
// - correlator lengths 0..16 chips
`timescale 1ns/1ps
module tsf_frame_sync
    import tsf_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // chip stream from clock recovery
    input  wire logic        chipValid,
    input  wire logic        chipData,
    input  wire logic        symSync,
    // framer results
    output logic             frameSyncPulse,
    output logic             matchBitValid,
    output logic             matchBit,
    output logic             wakeFound,
    output logic             codeViolation,
    output logic             searching
);
    import tsf_pkg::*;

    logic [7:0]  cfgQ [2][NFLD];     // both configuration sets
    logic [1:0]  ctrlQ;              // set select, self-polling
    logic        apQ, apWrQ;         // pending data phase
    logic [7:0]  apIdxQ;             // index of pending access
    logic [31:0] rdataQ;             // read data for data phase
    logic        symSyncQ;           // previous sync level
    logic        c1Q, c2Q;           // last two chips
    logic [1:0]  histQ;              // chips of history held
    logic        cvQ;                // violation pulse
    tsf_wst_e    wStQ, wStD;         // wake unit state
    logic [15:0] wsrQ;               // wake pattern shifter
    logic [4:0]  wFillQ;             // chips in wake shifter
    logic [6:0]  wcQ;                // window chip counter
    logic        wakeQ;              // wake-found pulse
    tsf_fst_e    fStQ, fStD;         // framer state
    logic [31:0] fsrQ;               // framer chip shifter
    logic [5:0]  fFillQ;             // chips since last clear
    logic        chipQ;              // a chip entered last cycle
    logic [7:0]  gapQ;               // gap chip counter
    logic        fsyncQ, mbvQ, mbQ;  // result registers
    logic        fsyncD, fillClr, gapClr;

    // bus decode; registers answer with zero wait states
    wire        addrPh = hsel & htrans[1] & hready;
    wire [7:0]  busIdx = haddr[9:2];
    wire        wrEn   = apQ & apWrQ;
    wire        sel    = ctrlQ[CTRL_SEL];
    wire        poll   = ctrlQ[CTRL_POLL];

    // selected set feeds all logic
    wire [6:0]  wCnt  = cfgQ[sel][F_WCNT][6:0];
    wire tsf_crit_e crit = tsf_crit_e'(cfgQ[sel][F_CRIT][1:0]);
    wire tsf_arr_e  arr  = tsf_arr_e'(cfgQ[sel][F_MODE][1:0]);
    wire [4:0]  lenA  = cfgQ[sel][F_LENA][4:0];
    wire [4:0]  lenB  = cfgQ[sel][F_LENB][4:0];
    wire [7:0]  gap   = cfgQ[sel][F_GAP];
    wire [15:0] wPat  = {cfgQ[sel][F_WPT1], cfgQ[sel][F_WPT0]};
    wire [15:0] patA  = {cfgQ[sel][F_PTA1], cfgQ[sel][F_PTA0]};
    wire [15:0] patB  = {cfgQ[sel][F_PTB1], cfgQ[sel][F_PTB0]};

    // status word seen by software
    wire [31:0] statW = {15'h0, mbQ, 2'h0, wStQ, 1'b0, fStQ, 1'b0, wcQ};
    wire [31:0] rdNext = (busIdx == IDX_CTRL) ? {30'h0, ctrlQ} :
                         (busIdx == IDX_STAT) ? statW : 32'h0;

    assign hrdata    = rdataQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase capture; read data is prepared here
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            apQ    <= 1'b0;
            apWrQ  <= 1'b0;
            apIdxQ <= 8'h00;
            rdataQ <= 32'h0;
        end else begin
            apQ    <= addrPh;
            apWrQ  <= hwrite;
            apIdxQ <= busIdx;
            rdataQ <= (addrPh & ~hwrite) ? rdNext : 32'h0;
        end
    end

    // write-only config fields, stored masked to their width
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrlQ <= 2'h0;
            for (int f = 0; f < NFLD; f++) begin
                cfgQ[0][f] <= CFG_RST;
                cfgQ[1][f] <= CFG_RST;
            end
        end else if (wrEn) begin
            if (apIdxQ == IDX_CTRL)
                ctrlQ <= hwdata[1:0];
            for (int f = 0; f < NFLD; f++) begin
                if (apIdxQ == IDX_A[f])
                    cfgQ[0][f] <= hwdata[7:0] & FLD_MASK[f];
                if (apIdxQ == IDX_B[f])
                    cfgQ[1][f] <= hwdata[7:0] & FLD_MASK[f];
            end
        end
    end

    // chip history; cleared at sync so old chips never count
    wire syncRise = symSync & ~symSyncQ;
    wire cvNow  = chipValid & (histQ == HIST_FULL) & (chipData == c1Q)
                & (c1Q == c2Q);
    wire eqPair = chipValid & (histQ != 2'h0) & (chipData == c1Q);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            symSyncQ <= 1'b0;
            c1Q      <= 1'b0;
            c2Q      <= 1'b0;
            histQ    <= 2'h0;
            cvQ      <= 1'b0;
        end else begin
            symSyncQ <= symSync;
            cvQ      <= cvNow;
            if (syncRise)
                histQ <= 2'h0;
            else if (chipValid & (histQ != HIST_FULL))
                histQ <= histQ + 2'h1;
            if (chipValid) begin
                c1Q <= chipData;
                c2Q <= c1Q;
            end
        end
    end

    // wake unit: pattern compare waits for a full shifter
    wire wElapsed = (wcQ == wCnt);
    wire patHit = (wFillQ == WFILL_MAX) & (wsrQ == wPat) & (wCnt != 7'h0);
    logic wOk;

    always_comb begin
        wStD = wStQ;
        wOk  = 1'b0;
        case (wStQ)
            WS_IDLE: begin
                if (syncRise & poll)
                    wStD = WS_SRCH;
            end
            WS_SRCH: begin
                if (!symSync) begin
                    wStD = WS_IDLE;
                end else begin
                    case (crit)
                        CR_PAT: begin
                            wOk = patHit;
                            if (patHit | wElapsed)
                                wStD = WS_DONE;
                        end
                        CR_RAND: begin
                            wOk = wElapsed & ~cvNow;
                            if (cvNow | wElapsed)
                                wStD = WS_DONE;
                        end
                        CR_EQ: begin
                            wOk = wElapsed & ~eqPair;
                            if (eqPair | wElapsed)
                                wStD = WS_DONE;
                        end
                        default: begin
                            wOk  = 1'b1;
                            wStD = WS_DONE;
                        end
                    endcase
                end
            end
            WS_DONE: begin
                if (!symSync)
                    wStD = WS_IDLE;
            end
            default: wStD = WS_IDLE;
        endcase
    end

    // window counter: clear at sync, count chips to limit
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wStQ   <= WS_IDLE;
            wsrQ   <= 16'h0;
            wFillQ <= 5'h0;
            wcQ    <= 7'h0;
            wakeQ  <= 1'b0;
        end else begin
            wStQ  <= wStD;
            wakeQ <= wOk;
            if (syncRise) begin
                wFillQ <= 5'h0;
                wcQ    <= 7'h0;
            end else if (chipValid & (wStQ == WS_SRCH)) begin
                wsrQ <= {wsrQ[14:0], chipData};
                if (wFillQ != WFILL_MAX)
                    wFillQ <= wFillQ + 5'h1;
                if (wcQ != wCnt)
                    wcQ <= wcQ + 7'h1;
            end
        end
    end

    // masked compare of newest chips; patterns are raw chips so
    // violation pairs match like any other chip
    function automatic logic corr(input logic [15:0] sr,
                                  input logic [15:0] pat,
                                  input logic [4:0]  len,
                                  input logic [5:0]  fill);
        logic [15:0] m;
        m = (len >= CORR_LEN) ? 16'hffff : (16'hffff >> (CORR_LEN - len));
        return (((sr ^ pat) & m) == 16'h0) && (fill >= {1'b0, len});
    endfunction

    // the older half only counts chips beyond the first sixteen
    wire [5:0] fillHi = (fFillQ >= 6'h10) ? (fFillQ - 6'h10) : 6'h0;
    wire matchA = corr(fsrQ[15:0], patA, lenA, fFillQ);
    wire matchB = corr(fsrQ[15:0], patB, lenB, fFillQ);
    // single mode: B is the older half, valid only when A is 16
    wire hitOne = matchA & corr(fsrQ[31:16], patB, lenB, fillHi);
    wire hitA = matchA & (lenA != 5'h0);
    wire hitB = matchB & (lenB != 5'h0);
    wire start = poll ? wakeQ : syncRise;
    wire gapEnd = (gapQ + 8'h1) == gap;

    // framer sequence; a new start re-arms only from idle or done
    always_comb begin
        fStD    = fStQ;
        fsyncD  = 1'b0;
        fillClr = 1'b0;
        gapClr  = 1'b0;
        case (fStQ)
            FS_SRCH: begin
                if (!symSync) begin
                    fStD = FS_IDLE;
                end else if (chipQ) begin
                    case (arr)
                        ARR_SINGLE: fsyncD = hitOne;
                        ARR_GAP: begin
                            if (hitA) begin
                                fStD    = (gap == 8'h0) ? FS_SRCHB
                                                        : FS_GAP;
                                fillClr = 1'b1;
                                gapClr  = 1'b1;
                            end
                        end
                        default: fsyncD = hitA | hitB;
                    endcase
                    if (fsyncD)
                        fStD = FS_DONE;
                end
            end
            FS_GAP: begin
                if (!symSync) begin
                    fStD = FS_IDLE;
                end else if (chipQ & gapEnd) begin
                    fStD    = FS_SRCHB;
                    fillClr = 1'b1;
                end
            end
            FS_SRCHB: begin
                if (!symSync) begin
                    fStD = FS_IDLE;
                end else if (chipQ & hitB) begin
                    fsyncD = 1'b1;
                    fStD   = FS_DONE;
                end
            end
            FS_IDLE, FS_DONE: fStD = fStQ;
            default: fStD = FS_IDLE;
        endcase
        if (start & (fStQ == FS_IDLE || fStQ == FS_DONE)) begin
            fStD    = FS_SRCH;
            fillClr = 1'b1;
        end
    end

    // framer registers; chips shift in at the low end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            fStQ   <= FS_IDLE;
            fsrQ   <= 32'h0;
            fFillQ <= 6'h0;
            chipQ  <= 1'b0;
            gapQ   <= 8'h0;
            fsyncQ <= 1'b0;
            mbvQ   <= 1'b0;
            mbQ    <= 1'b0;
        end else begin
            fStQ   <= fStD;
            chipQ  <= chipValid;
            fsyncQ <= fsyncD;
            mbvQ   <= fsyncD & (arr == ARR_EXT);
            if (fsyncD)
                mbQ <= ~hitA & (arr != ARR_SINGLE);
            if (chipValid)
                fsrQ <= {fsrQ[30:0], chipData};
            if (fillClr)
                fFillQ <= {5'h0, chipValid};
            else if (chipValid & (fFillQ != FILL_MAX))
                fFillQ <= fFillQ + 6'h1;
            if (gapClr)
                gapQ <= 8'h0;
            else if (chipQ & (fStQ == FS_GAP))
                gapQ <= gapQ + 8'h1;
        end
    end

    assign frameSyncPulse = fsyncQ;
    assign matchBitValid  = mbvQ;
    assign matchBit       = mbQ;
    assign wakeFound      = wakeQ;
    assign codeViolation  = cvQ;
    assign searching      = (fStQ != FS_IDLE) & (fStQ != FS_DONE);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_frame_sync_pulse_single: assert property (fsyncQ |=> !fsyncQ)
        else $error("frame sync longer than one cycle");
    a_frame_sync_pulse_done: assert property (fsyncQ |-> fStQ == FS_DONE)
        else $error("framer kept searching after match");
    a_sync_lost: assert property (searching && !symSync
        && !start |=> fStQ == FS_IDLE)
        else $error("search survived loss of sync");
    a_slave_start: assert property (syncRise && !poll
        |=> fStQ == FS_SRCH)
        else $error("slave start not taken");
    a_wake_zero: assert property (wStQ == WS_SRCH && symSync
        && wCnt == 7'h0 && (crit == CR_RAND || crit == CR_EQ)
        |=> wakeFound)
        else $error("zero window did not wake at once");
    a_pat_zero: assert property (wStQ == WS_SRCH && crit == CR_PAT
        && wCnt == 7'h0 |=> !wakeFound)
        else $error("pattern mode woke with zero window");
    a_pat_full: assert property (wakeFound && $past(crit == CR_PAT)
        |-> $past(wFillQ) == WFILL_MAX)
        else $error("pattern compared before shifter full");
    a_win_clear: assert property (syncRise |=> wcQ == 7'h0)
        else $error("window counter not cleared at sync");
    a_cv_three: assert property (chipValid && histQ == HIST_FULL
        && chipData == c1Q && c1Q == c2Q |=> codeViolation)
        else $error("three equal chips not flagged");
    a_ext_bit: assert property (fsyncD && arr == ARR_EXT
        |=> matchBitValid && frameSyncPulse)
        else $error("indicator bit missing in extended mode");

    c_par_sync: cover property (fsyncQ && arr == ARR_PAR);
    c_gap_sync: cover property (fStQ == FS_GAP ##[1:300] fsyncQ);
    c_one_sync: cover property (fsyncQ && arr == ARR_SINGLE);
    c_wake: cover property (wakeFound && crit == CR_PAT);
endmodule

// File: logic/tsf_pkg.sv
package tsf_pkg;
    // number of byte-wide config fields per set
    localparam int NFLD = 12;
    // field slots inside one configuration set
    localparam int F_WCNT = 0;
    localparam int F_CRIT = 1;
    localparam int F_WPT0 = 2;
    localparam int F_WPT1 = 3;
    localparam int F_MODE = 4;
    localparam int F_LENA = 5;
    localparam int F_LENB = 6;
    localparam int F_GAP  = 7;
    localparam int F_PTA0 = 8;
    localparam int F_PTA1 = 9;
    localparam int F_PTB0 = 10;
    localparam int F_PTB1 = 11;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_A [NFLD] = '{8'h28, 8'h25, 8'h26, 8'h27,
        8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89};
    localparam logic [7:0] IDX_B [NFLD] = '{8'h49, 8'h46, 8'h47, 8'h48,
        8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9};
    // implemented bits of each field; others read and store zero
    localparam logic [7:0] FLD_MASK [NFLD] = '{8'h7f, 8'h03, 8'hff, 8'hff,
        8'h03, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] IDX_CTRL = 8'hc0;
    localparam logic [7:0] IDX_STAT = 8'hc1;
    localparam int CTRL_SEL  = 0;
    localparam int CTRL_POLL = 1;
    // correlator geometry
    localparam logic [4:0] CORR_LEN  = 5'h10;
    localparam logic [5:0] FILL_MAX  = 6'h20;
    localparam logic [4:0] WFILL_MAX = 5'h10;
    localparam logic [1:0] HIST_FULL = 2'h2;
    // wake-up criterion encodings
    typedef enum logic [1:0] {
        CR_PAT = 2'b00, CR_RAND = 2'b01, CR_EQ = 2'b10, CR_RATE = 2'b11
    } tsf_crit_e;
    // correlator arrangement encodings
    typedef enum logic [1:0] {
        ARR_SINGLE = 2'b00, ARR_PAR = 2'b01, ARR_GAP = 2'b10, ARR_EXT = 2'b11
    } tsf_arr_e;
    // framer states, gray along idle-search-gap-searchB-done
    typedef enum logic [2:0] {
        FS_IDLE = 3'b000, FS_SRCH = 3'b001, FS_GAP = 3'b011,
        FS_SRCHB = 3'b010, FS_DONE = 3'b110
    } tsf_fst_e;
    // wake-up unit states
    typedef enum logic [1:0] {
        WS_IDLE = 2'b00, WS_SRCH = 2'b01, WS_DONE = 2'b11
    } tsf_wst_e;
endpackage

// File: verification/tsf_chip_source.sv
`timescale 1ns/1ps
// upstream recovery model: sync level and one-cycle chip strobes
module tsf_chip_source (
    // clock
    input  wire logic ref_clk,
    // chip stream towards the framer
    output logic      chipValid,
    output logic      chipData,
    output logic      symSync
);
    // quiet link at time zero
    initial begin
        chipValid = 1'b0;
        chipData  = 1'b0;
        symSync   = 1'b0;
    end
    // symbol sync level, changed just after an edge
    task automatic setSync(input logic lvl);
        @(posedge ref_clk);
        symSync <= lvl;
    endtask
    // n chips, bit n-1 first, space idle cycles between chips;
    // caller supplies run-in and identifier content
    task automatic sendChips(input logic [31:0] v, input int n,
                             input int space);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk);
            chipValid <= 1'b1;
            chipData  <= v[i];
            for (int k = 0; k < space; k++) begin
                @(posedge ref_clk);
                chipValid <= 1'b0;
                // data is not held between strobes
                chipData  <= ~v[i];
            end
        end
        @(posedge ref_clk);
        chipValid <= 1'b0;
        chipData  <= ~v[0];
    endtask
endmodule

// File: verification/tsf_frame_sync_bench.sv
`timescale 1ns/1ps
module tsf_frame_sync_bench;
    import tsf_pkg::*;
    // clock, reset and bus
    logic        ref_clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    // chip link and results
    logic        chipValid, chipData, symSync, frameSyncPulse;
    logic        matchBitValid, matchBit, wakeFound, codeViolation;
    logic        searching, prevSync;
    // bookkeeping
    int          nMismatch, samplesChecked, cycles;
    int          nSync, nBitV, nWake, nViol;

    tsf_frame_sync i_tsf_frame_sync (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chipValid(chipValid),
        .chipData(chipData), .symSync(symSync),
        .frameSyncPulse(frameSyncPulse), .matchBitValid(matchBitValid),
        .matchBit(matchBit), .wakeFound(wakeFound),
        .codeViolation(codeViolation), .searching(searching));
    tsf_chip_source i_tsf_chip_source (
        .ref_clk(ref_clk), .chipValid(chipValid), .chipData(chipData),
        .symSync(symSync));

    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // pulse counters sampled mid-cycle, away from the launching edge
    always @(negedge ref_clk) begin
        if (frameSyncPulse === 1'b1) check(prevSync, 1'b0);
        prevSync = frameSyncPulse;
        nSync += (frameSyncPulse === 1'b1);
        nBitV += (matchBitValid === 1'b1);
        nWake += (wakeFound === 1'b1);
        nViol += (codeViolation === 1'b1);
    end
    // hang guard: whole run is under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            nMismatch++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            nMismatch++;
        end
    endtask
    // one ahb-lite single transfer; entered just after a rising edge
    // no wait-state count is assumed; only the hang guard ends a wait
    task automatic busXfer(input logic wr, input logic [7:0] idx,
                           input logic [31:0] wd, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        // address phase stands until hready is seen high
        do begin
            @(posedge ref_clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        // data phase stands until hready is seen high again
        do begin
            @(posedge ref_clk);
        end while (hreadyout !== 1'b1);
        // read data taken at the closing edge, before it is relaunched
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        busXfer(1'b1, idx, {24'h0, v}, rd);
    endtask
    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        busXfer(1'b0, idx, 32'h0, rd);
        check(rd, exp);
    endtask
    // program the framer fields of one configuration set
    task automatic cfgFramer(input logic s, input logic [1:0] arr,
        input logic [7:0] la, lb, input logic [15:0] pa, pb,
        input logic [7:0] gap);
        logic [7:0] ix [NFLD];
        if (s)
            ix = IDX_B;
        else
            ix = IDX_A;
        wr(ix[F_MODE], {6'h0, arr});
        wr(ix[F_LENA], la);
        wr(ix[F_LENB], lb);
        wr(ix[F_GAP], gap);
        wr(ix[F_PTA0], pa[7:0]);
        wr(ix[F_PTA1], pa[15:8]);
        wr(ix[F_PTB0], pb[7:0]);
        wr(ix[F_PTB1], pb[15:8]);
    endtask
    // slave-mode frame: sync, chips, result, then sync loss aborts
    task automatic frame(input logic [31:0] v, input int n, input int expN,
                         input logic expBit, input int expViol);
        nSync = 0;
        nBitV = 0;
        nViol = 0;
        i_tsf_chip_source.setSync(1'b1);
        repeat (2) @(posedge ref_clk);
        i_tsf_chip_source.sendChips(v, n, 1);
        repeat (4) @(negedge ref_clk);
        check(nSync, expN);
        check(nViol, expViol);
        if (expN > 0) check(matchBit, expBit);
        check(searching, expN == 0);
        i_tsf_chip_source.setSync(1'b0);
        repeat (3) @(negedge ref_clk);
        check(searching, 1'b0);
        @(posedge ref_clk);
    endtask
    // self-polling wake run on set A; framer must follow the wake
    task automatic wakeRun(input tsf_crit_e c, input logic [7:0] cnt,
                           input logic [31:0] v, input int n, input int exp);
        wr(IDX_A[F_WCNT], cnt);
        wr(IDX_A[F_CRIT], {6'h0, c});
        nWake = 0;
        i_tsf_chip_source.setSync(1'b1);
        i_tsf_chip_source.sendChips(v, n, 0);
        repeat (5) @(negedge ref_clk);
        check(nWake, exp);
        check(searching, exp);
        i_tsf_chip_source.setSync(1'b0);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic conclude();
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        // look mid-cycle so the released outputs have settled
        @(negedge ref_clk);
        check({hresp, hreadyout, frameSyncPulse, matchBitValid, wakeFound,
               searching, codeViolation, matchBit}, 32'h40);
        @(posedge ref_clk);
        rdChk(IDX_CTRL, 32'h0);
        rdChk(IDX_A[F_WCNT], 32'h0);
        rdChk(8'hff, 32'h0);
        // parallel: A is 1001, B is 110100, upper pattern bits ignored
        cfgFramer(0, ARR_PAR, 4, 6, 16'hfff9, 16'hffb4, 0);
        frame(32'haa99, 16, 1, 1'b0, 0);
        check(nBitV, 0);
        frame(32'h2b4, 10, 1, 1'b1, 0);
        // status: framer done, wake idle, counter 0, B matched
        rdChk(IDX_STAT, 32'h10600);
        frame(32'ha2, 8, 0, 1'b0, 1);
        cfgFramer(0, ARR_EXT, 4, 6, 16'hfff9, 16'hffb4, 0);
        frame(32'h2b4, 10, 1, 1'b1, 0);
        check(nBitV, 1);
        frame(32'haa99, 16, 1, 1'b0, 0);
        check(nBitV, 1);
        // single: B chips first, then the 16 chips of A
        cfgFramer(0, ARR_SINGLE, 8'h10, 4, 16'h5a5a, 16'h000d, 0);
        frame(32'had5a5a, 24, 1, 1'b0, 0);
        frame(32'ha95a5a, 24, 0, 1'b0, 0);
        // gap: A, four gap chips, then B; B alone must not sync
        cfgFramer(0, ARR_GAP, 4, 6, 16'hfff9, 16'hffb4, 4);
        frame(32'h2a5b4, 18, 1, 1'b1, 0);
        frame(32'h2b4, 10, 0, 1'b0, 0);
        // set B governs once selected; its pattern opens with a violation
        cfgFramer(1, ARR_PAR, 4, 0, 16'h000e, 16'h0000, 0);
        wr(IDX_CTRL, 8'h01);
        rdChk(IDX_CTRL, 32'h1);
        frame(32'hae, 8, 1, 1'b0, 1);
        // self-polling with set A
        wr(IDX_CTRL, 8'h02);
        wr(IDX_A[F_WPT0], 8'h5a);
        wr(IDX_A[F_WPT1], 8'h5a);
        wakeRun(CR_PAT, 8'h00, 0, 0, 0);
        wakeRun(CR_RAND, 8'h80, 0, 0, 1);
        wakeRun(CR_EQ, 8'h00, 0, 0, 1);
        wakeRun(CR_RATE, 8'h05, 0, 0, 1);
        wakeRun(CR_EQ, 8'h08, 32'h55, 7, 0);
        wakeRun(CR_EQ, 8'h08, 32'haa, 8, 1);
        wakeRun(CR_EQ, 8'h08, 32'ha6, 8, 0);
        wakeRun(CR_RAND, 8'h08, 32'ha6, 8, 1);
        wakeRun(CR_RAND, 8'h08, 32'ha2, 8, 0);
        wakeRun(CR_PAT, 8'h11, 32'h15a5a, 17, 1);
        wakeRun(CR_PAT, 8'h11, 32'h1a5a5, 17, 0);
        conclude();
    end
endmodule
